/* File: nand_seq_pkg.sv */
// Shared constants and types for the NAND program/erase/status controller.
package nand_seq_pkg;

	// ==========================================================
	// Command bytes written in command cycles.
	localparam logic [7:0] CMD_READ_SETUP = 8'h00;
	localparam logic [7:0] CMD_READ_COPYBACK = 8'h35;
	localparam logic [7:0] CMD_PAGE_INPUT = 8'h80;
	localparam logic [7:0] CMD_PLANE2_INPUT = 8'h81;
	localparam logic [7:0] CMD_COPY_INPUT = 8'h85;
	localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
	localparam logic [7:0] CMD_DUMMY_PROG = 8'h11;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_PLANE_STATUS = 8'hf1;
	localparam logic [7:0] CMD_RESET = 8'hff;

	// ==========================================================
	// Status byte layout and the masks that keep only used bits.
	localparam int STAT_FAIL_BIT = 0;
	localparam int STAT_READY_BIT = 6;
	localparam int STAT_UNPROT_BIT = 7;
	localparam logic [7:0] STAT_MASK_BASIC = 8'hc1;
	localparam logic [7:0] STAT_MASK_PLANE = 8'hc7;

	// ==========================================================
	// Addressing: plane select bit inside the row address.
	localparam int ROW_W = 24;
	localparam int COL_W = 16;
	localparam int ROW_PLANE_BIT = 6;
	localparam int PAGE_LEN_W = 14;

	// ==========================================================
	// Pin timing in ns and derived clock counts (rounded up).
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_SETUP_NS = 25;
	localparam int T_PULSE_NS = 25;
	localparam int T_HOLD_NS = 25;
	localparam int T_BUSY_START_NS = 100;
	localparam int SYNC_STAGES = 2;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_START_CYC =
		(T_BUSY_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TCNT_W = 4;

	// ==========================================================
	// Kinds of single bus cycle.
	typedef enum logic [1:0] {
		CYC_CMD = 2'b00,
		CYC_ADDR = 2'b01,
		CYC_WRITE = 2'b10,
		CYC_READ = 2'b11
	} cyc_kind_t;

	// Operations the user may request.
	typedef enum logic [3:0] {
		OP_PROG_2PLANE = 4'h0,
		OP_READ_COPYBACK = 4'h1,
		OP_COPYBACK = 4'h2,
		OP_COPYBACK_2PLANE = 4'h3,
		OP_ERASE = 4'h4,
		OP_ERASE_2PLANE = 4'h5,
		OP_STATUS = 4'h6,
		OP_PLANE_STATUS = 4'h7,
		OP_RESET = 4'h8
	} op_t;

	// Steps of an operation's sequence.
	typedef enum logic [3:0] {
		K_CMD = 4'h0,
		K_ADR5A = 4'h1,
		K_ADR5B = 4'h2,
		K_ADR3A = 4'h3,
		K_ADR3B = 4'h4,
		K_COL2 = 4'h5,
		K_DATA = 4'h6,
		K_WAIT = 4'h7,
		K_STAT = 4'h8,
		K_END = 4'h9
	} step_kind_t;

	// One step: its kind and, for a command, the command byte.
	typedef struct packed {
		step_kind_t kind;
		logic [7:0] arg;
	} step_t;

endpackage

/* File: nand_bus_cycle.sv */
// One command, address, write or read cycle on the NAND pins.
`timescale 1ns/1ps
`default_nettype none

module nand_bus_cycle (
	input wire logic i_clk_sys, // System clock.
	input wire logic i_rst, // Asynchronous reset, active high.
	input wire logic i_go, // One-cycle pulse that starts a cycle.
	input wire nand_seq_pkg::cyc_kind_t i_kind, // Kind of cycle.
	input wire logic [7:0] i_byte, // Byte to drive.
	output logic o_done, // One-cycle pulse at the end of a cycle.
	output logic [7:0] o_rbyte, // Byte captured in a read cycle.
	output logic o_cle, // Command latch enable.
	output logic o_ale, // Address latch enable.
	output logic o_we_n, // Write strobe, active low.
	output logic o_read_strobe_n, // Read strobe, active low.
	output logic [7:0] o_dq, // Data bus drive value.
	output logic o_dq_oe, // Data bus drive enable.
	input wire logic [7:0] i_dq // Data bus level from the pins.
);
	import nand_seq_pkg::*;

	// ==========================================================
	// Phases of one bus cycle.
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_SETUP = 2'b01,
		PH_LOW = 2'b10,
		PH_HOLD = 2'b11
	} phase_t;

	phase_t phase; // Current phase.
	logic [TCNT_W-1:0] cnt; // Cycles left in this phase.
	logic is_read; // The running cycle reads.
	logic [7:0] dq_s1; // First synchroniser stage.
	logic [7:0] dq_s2; // Second synchroniser stage.

	// The data pins are asynchronous to us, so two flops come first.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			dq_s1 <= 8'h00;
			dq_s2 <= 8'h00;
		end else begin
			dq_s1 <= i_dq;
			dq_s2 <= dq_s1;
		end
	end

	// Walks setup, strobe low and hold, moving the pins with it.
	// A read keeps its strobe low for the synchroniser delay as well,
	// so the byte captured is the one the device drove.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			phase <= PH_IDLE;
			cnt <= '0;
			is_read <= 1'b0;
			o_done <= 1'b0;
			o_rbyte <= 8'h00;
			o_cle <= 1'b0;
			o_ale <= 1'b0;
			o_we_n <= 1'b1;
			o_read_strobe_n <= 1'b1;
			o_dq <= 8'h00;
			o_dq_oe <= 1'b0;
		end else begin
			o_done <= 1'b0;
			unique case (phase)
				PH_IDLE: begin
					// A new cycle sets up latch enables and data.
					if (i_go) begin
						phase <= PH_SETUP;
						cnt <= TCNT_W'(SETUP_CYC - 1);
						is_read <= (i_kind == CYC_READ);
						o_cle <= (i_kind == CYC_CMD);
						o_ale <= (i_kind == CYC_ADDR);
						o_dq <= i_byte;
						o_dq_oe <= (i_kind != CYC_READ);
					end
				end
				PH_SETUP: begin
					// Setup time over: drop the proper strobe.
					if (cnt == '0) begin
						phase <= PH_LOW;
						if (is_read) begin
							o_read_strobe_n <= 1'b0;
							cnt <= TCNT_W'(PULSE_CYC + SYNC_STAGES - 1);
						end else begin
							o_we_n <= 1'b0;
							cnt <= TCNT_W'(PULSE_CYC - 1);
						end
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				PH_LOW: begin
					// Rising write strobe latches the byte in the device.
					if (cnt == '0) begin
						phase <= PH_HOLD;
						cnt <= TCNT_W'(HOLD_CYC - 1);
						o_we_n <= 1'b1;
						o_read_strobe_n <= 1'b1;
						if (is_read) begin
							o_rbyte <= dq_s2;
						end
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				PH_HOLD: begin
					// Hold time over: release the bus and report.
					if (cnt == '0) begin
						phase <= PH_IDLE;
						o_cle <= 1'b0;
						o_ale <= 1'b0;
						o_dq_oe <= 1'b0;
						o_done <= 1'b1;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
			endcase
		end
	end

endmodule
`default_nettype wire

/* File: nand_program_erase_status_sequencer.sv */
// Controller that drives NAND program, erase and status sequences.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RULE_01] Two-plane: first plane ends with dummy program
// [RULE_02] Second plane data follows 81h and address
// [RULE_03] Last plane ends with true program confirm
// [RULE_04] Between 11h and 81h only status or reset
// [RULE_05] Read-for-copy-back loads whole page into buffer
// [RULE_06] Copy-back: 85h with destination, then confirm
// [RULE_07] Copy-back may take random data input
// [RULE_08] Copy-back source and destination share one plane
// [RULE_09] Program completion shows on ready/busy pin
// [RULE_10] Status mode holds until next valid command
// [RULE_11] Erase: setup, three address cycles, confirm
// [RULE_12] Erase address ignores page bits
// [RULE_13] Erase starts at confirm write strobe rising
// [RULE_14] Two-plane erase: two setups, one confirm
// [RULE_15] Status read drives status on data pins
// [RULE_16] Status updates without another read strobe
// [RULE_17] Reissue read command after status mid-read
// [RULE_18] Status bit 0 gives pass or fail
// [RULE_19] Status bit 6 is ready, zero when busy
// [RULE_20] Status bit 7 is zero when protected
// [RULE_21] Extended status bits 1 and 2 per plane
// [RULE_22] Controller masks unused status bits
// [RULE_23] Only status and reset accepted while programming
// [RULE_24] Confirm without data does not program
// [RULE_25] Out-of-order sequences report failure
module nand_program_erase_status_sequencer #(
	parameter int LEN_W = nand_seq_pkg::PAGE_LEN_W, // Byte count width.
	parameter int PLANE_BIT = nand_seq_pkg::ROW_PLANE_BIT // Plane bit.
) (
	input wire logic i_clk_sys, // System clock, 20 MHz.
	input wire logic i_rst, // Asynchronous reset, active high.
	input wire logic i_start, // Pulse: start the operation below.
	input wire nand_seq_pkg::op_t i_op, // Operation to run.
	input wire logic [nand_seq_pkg::COL_W-1:0] i_col, // Start column.
	input wire logic [nand_seq_pkg::ROW_W-1:0] i_row_a, // First row.
	input wire logic [nand_seq_pkg::ROW_W-1:0] i_row_b, // Second row.
	input wire logic i_rand_en, // Copy-back with random data input.
	input wire logic [nand_seq_pkg::COL_W-1:0] i_rand_col, // Its column.
	input wire logic [LEN_W-1:0] i_len, // Data bytes per plane.
	input wire logic [7:0] i_wdata, // Write data byte.
	input wire logic i_wvalid, // Write data valid.
	output logic o_wready, // Write data taken when valid too.
	output logic o_busy, // Operation in progress.
	output logic o_done, // Pulse: operation finished.
	output logic o_refused, // Pulse: start refused.
	output logic [7:0] o_status, // Last status byte, unused bits masked.
	output logic o_fail, // Last status reported a failure.
	output logic o_ce_n, // Chip enable, active low.
	output logic o_cle, // Command latch enable.
	output logic o_ale, // Address latch enable.
	output logic o_we_n, // Write strobe, active low.
	output logic o_read_strobe_n, // Read strobe, active low.
	output logic o_wp_n, // Write protect, active low.
	output logic [7:0] o_dq, // Data bus drive value.
	output logic o_dq_oe, // Data bus drive enable.
	input wire logic [7:0] i_dq, // Data bus level.
	input wire logic i_rb // Ready/busy pin, low while busy.
);
	import nand_seq_pkg::*;

	// ==========================================================
	// Elaboration checks.
	if (LEN_W < PAGE_LEN_W || LEN_W > 16) begin : g_len_chk
		$error("LEN_W must cover one page and stay within 16 bits");
	end
	if (PLANE_BIT >= ROW_W) begin : g_plane_chk
		$error("PLANE_BIT lies outside the row address");
	end

	// ==========================================================
	// Sequences, one step per index.
	function automatic step_t seq_step(op_t op, logic [3:0] i, logic rnd);
		step_t s;
		s = '{K_END, 8'h00};
		unique case (op)
			OP_PROG_2PLANE: begin
				case (i)
					4'h0: s = '{K_CMD, CMD_PAGE_INPUT};
					4'h1: s = '{K_ADR5A, 8'h00};
					4'h2: s = '{K_DATA, 8'h00};
					4'h3: s = '{K_CMD, CMD_DUMMY_PROG}; // [RULE_01]
					4'h4: s = '{K_WAIT, 8'h00}; // [RULE_04]
					4'h5: s = '{K_CMD, CMD_PLANE2_INPUT}; // [RULE_02]
					4'h6: s = '{K_ADR5B, 8'h00};
					4'h7: s = '{K_DATA, 8'h00};
					4'h8: s = '{K_CMD, CMD_PROG_CONFIRM}; // [RULE_03]
					4'h9: s = '{K_WAIT, 8'h00}; // [RULE_09]
					4'ha: s = '{K_STAT, 8'h00};
					default: s = '{K_END, 8'h00};
				endcase
			end
			OP_READ_COPYBACK: begin
				// Always opens with the read command. [RULE_17]
				case (i)
					4'h0: s = '{K_CMD, CMD_READ_SETUP};
					4'h1: s = '{K_ADR5A, 8'h00};
					4'h2: s = '{K_CMD, CMD_READ_COPYBACK}; // [RULE_05]
					4'h3: s = '{K_WAIT, 8'h00};
					default: s = '{K_END, 8'h00};
				endcase
			end
			OP_COPYBACK: begin
				case (i)
					4'h0: s = '{K_CMD, CMD_COPY_INPUT}; // [RULE_06]
					4'h1: s = '{K_ADR5B, 8'h00};
					4'h2: s = rnd ? step_t'{K_CMD, CMD_COPY_INPUT} // [RULE_07]
						: step_t'{K_CMD, CMD_PROG_CONFIRM};
					4'h3: s = rnd ? step_t'{K_COL2, 8'h00}
						: step_t'{K_WAIT, 8'h00};
					4'h4: s = rnd ? step_t'{K_DATA, 8'h00}
						: step_t'{K_STAT, 8'h00};
					4'h5: s = rnd ? step_t'{K_CMD, CMD_PROG_CONFIRM}
						: step_t'{K_END, 8'h00};
					4'h6: s = rnd ? step_t'{K_WAIT, 8'h00}
						: step_t'{K_END, 8'h00};
					4'h7: s = rnd ? step_t'{K_STAT, 8'h00}
						: step_t'{K_END, 8'h00};
					default: s = '{K_END, 8'h00};
				endcase
			end
			OP_COPYBACK_2PLANE: begin
				case (i)
					4'h0: s = '{K_CMD, CMD_COPY_INPUT};
					4'h1: s = '{K_ADR5A, 8'h00};
					4'h2: s = '{K_CMD, CMD_DUMMY_PROG}; // [RULE_01]
					4'h3: s = '{K_WAIT, 8'h00}; // [RULE_04]
					4'h4: s = '{K_CMD, CMD_PLANE2_INPUT}; // [RULE_02]
					4'h5: s = '{K_ADR5B, 8'h00};
					4'h6: s = '{K_CMD, CMD_PROG_CONFIRM}; // [RULE_03]
					4'h7: s = '{K_WAIT, 8'h00};
					4'h8: s = '{K_STAT, 8'h00};
					default: s = '{K_END, 8'h00};
				endcase
			end
			OP_ERASE, OP_ERASE_2PLANE: begin
				// Second setup only in the two-plane form. [RULE_11]
				case (i)
					4'h0: s = '{K_CMD, CMD_ERASE_SETUP};
					4'h1: s = '{K_ADR3A, 8'h00};
					4'h2: s = (op == OP_ERASE_2PLANE) // [RULE_14]
						? step_t'{K_CMD, CMD_ERASE_SETUP}
						: step_t'{K_CMD, CMD_ERASE_CONFIRM};
					4'h3: s = (op == OP_ERASE_2PLANE)
						? step_t'{K_ADR3B, 8'h00} : step_t'{K_WAIT, 8'h00};
					4'h4: s = (op == OP_ERASE_2PLANE)
						? step_t'{K_CMD, CMD_ERASE_CONFIRM}
						: step_t'{K_STAT, 8'h00};
					4'h5: s = (op == OP_ERASE_2PLANE)
						? step_t'{K_WAIT, 8'h00} : step_t'{K_END, 8'h00};
					4'h6: s = (op == OP_ERASE_2PLANE)
						? step_t'{K_STAT, 8'h00} : step_t'{K_END, 8'h00};
					default: s = '{K_END, 8'h00};
				endcase
			end
			OP_STATUS, OP_PLANE_STATUS: begin
				s = (i == 4'h0) ? step_t'{K_STAT, 8'h00}
					: step_t'{K_END, 8'h00};
			end
			OP_RESET: begin
				case (i)
					4'h0: s = '{K_CMD, CMD_RESET};
					4'h1: s = '{K_WAIT, 8'h00};
					default: s = '{K_END, 8'h00};
				endcase
			end
			default: s = '{K_END, 8'h00};
		endcase
		return s;
	endfunction

	// Address byte for a given group and position, low byte first.
	function automatic logic [7:0] addr_byte(step_kind_t k, logic [2:0] n,
		logic [COL_W-1:0] col, logic [ROW_W-1:0] row);
		logic [COL_W+ROW_W-1:0] all;
		all = {row, col};
		if (k == K_ADR3A || k == K_ADR3B) begin
			return row[8*n +: 8];
		end
		return all[8*n +: 8];
	endfunction

	// ==========================================================
	// Sequencer state.
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_FETCH = 3'b001,
		S_ISSUE = 3'b010,
		S_DATA = 3'b011,
		S_WAIT = 3'b100,
		S_FINISH = 3'b101
	} state_t;

	state_t state; // Sequencer state.
	op_t op; // Operation being run.
	logic rnd; // Random data input selected.
	logic [COL_W-1:0] col; // Start column.
	logic [COL_W-1:0] rcol; // Random input column.
	logic [ROW_W-1:0] row_a; // First row.
	logic [ROW_W-1:0] row_b; // Second row.
	logic [LEN_W-1:0] len; // Bytes per plane.
	logic [LEN_W-1:0] left; // Bytes left in this data phase.
	logic [3:0] idx; // Step index.
	logic [2:0] sub; // Byte index inside a step.
	step_kind_t kind; // Kind of the current step.
	logic [TCNT_W-1:0] wcnt; // Wait before sampling ready/busy.
	logic cyc_go; // Starts one bus cycle.
	cyc_kind_t cyc_kind; // Kind of that cycle.
	logic [7:0] cyc_byte; // Byte of that cycle.
	logic cyc_done; // Bus cycle finished.
	logic [7:0] cyc_rbyte; // Byte read by that cycle.
	logic rb_s1; // First ready/busy synchroniser stage.
	logic rb_s2; // Second ready/busy synchroniser stage.
	step_t cur; // Step at the current index.
	logic plane_a; // Plane of the first row.
	logic plane_b; // Plane of the second row.
	logic [2:0] last_sub; // Last byte index of the current group.

	assign cur = seq_step(op, idx, rnd);
	assign plane_a = i_row_a[PLANE_BIT];
	assign plane_b = i_row_b[PLANE_BIT];
	assign last_sub = (kind == K_ADR5A || kind == K_ADR5B) ? 3'd4 :
		(kind == K_COL2) ? 3'd1 : 3'd2;

	// The ready/busy pin is asynchronous: two flops before use.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
		end else begin
			rb_s1 <= i_rb;
			rb_s2 <= rb_s1;
		end
	end

	// ==========================================================
	// Main sequencer: starts, steps, data, waits and status capture.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state <= S_IDLE;
			op <= OP_STATUS;
			rnd <= 1'b0;
			col <= '0;
			rcol <= '0;
			row_a <= '0;
			row_b <= '0;
			len <= '0;
			left <= '0;
			idx <= 4'h0;
			sub <= 3'd0;
			kind <= K_END;
			wcnt <= '0;
			cyc_go <= 1'b0;
			cyc_kind <= CYC_CMD;
			cyc_byte <= 8'h00;
			o_wready <= 1'b0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_refused <= 1'b0;
			o_status <= 8'h00;
			o_fail <= 1'b0;
			o_ce_n <= 1'b1;
			o_wp_n <= 1'b1;
		end else begin
			cyc_go <= 1'b0;
			o_done <= 1'b0;
			o_refused <= 1'b0;
			unique case (state)
				S_IDLE: begin
					if (i_start) begin
						// Plane pairing and empty data are refused here.
						if ((i_op == OP_COPYBACK && plane_a != plane_b) // [RULE_08]
							|| ((i_op == OP_PROG_2PLANE
							|| i_op == OP_COPYBACK_2PLANE
							|| i_op == OP_ERASE_2PLANE)
							&& (plane_a || !plane_b)) // [RULE_14]
							|| (i_len == '0 && (i_op == OP_PROG_2PLANE
							|| (i_op == OP_COPYBACK && i_rand_en)))) begin // [RULE_24]
							o_refused <= 1'b1;
						end else begin
							state <= S_FETCH;
							op <= i_op;
							rnd <= i_rand_en;
							col <= i_col;
							rcol <= i_rand_col;
							row_a <= i_row_a;
							row_b <= i_row_b;
							len <= i_len;
							idx <= 4'h0;
							sub <= 3'd0;
							o_busy <= 1'b1;
							o_ce_n <= 1'b0;
						end
					end
				end
				S_FETCH: begin
					// Decode the step at idx; command, address and status steps launch their first cycle.
					kind <= cur.kind;
					sub <= 3'd0;
					unique case (cur.kind)
						K_CMD: begin
							cyc_kind <= CYC_CMD;
							cyc_byte <= cur.arg; // [RULE_13]
							cyc_go <= 1'b1;
							state <= S_ISSUE;
						end
						K_ADR5A, K_ADR3A: begin
							cyc_kind <= CYC_ADDR;
							cyc_byte <= addr_byte(cur.kind, 3'd0, col, row_a); // [RULE_11]
							cyc_go <= 1'b1;
							state <= S_ISSUE;
						end
						K_ADR5B, K_ADR3B: begin
							cyc_kind <= CYC_ADDR;
							cyc_byte <= addr_byte(cur.kind, 3'd0, col, row_b);
							cyc_go <= 1'b1;
							state <= S_ISSUE;
						end
						K_COL2: begin
							cyc_kind <= CYC_ADDR;
							cyc_byte <= rcol[7:0];
							cyc_go <= 1'b1;
							state <= S_ISSUE;
						end
						K_DATA: begin
							left <= len;
							state <= S_DATA;
						end
						K_WAIT: begin
							wcnt <= TCNT_W'(BUSY_START_CYC);
							state <= S_WAIT;
						end
						K_STAT: begin
							// Plane-wise status after two-plane work. [RULE_15]
							cyc_kind <= CYC_CMD;
							cyc_byte <= (op == OP_PLANE_STATUS
								|| op == OP_PROG_2PLANE
								|| op == OP_COPYBACK_2PLANE
								|| op == OP_ERASE_2PLANE)
								? CMD_PLANE_STATUS : CMD_STATUS;
							cyc_go <= 1'b1;
							state <= S_ISSUE;
						end
						K_END: begin
							state <= S_FINISH;
						end
						default: begin
							state <= S_FINISH;
						end
					endcase
				end
				S_ISSUE: begin
					// A finished cycle either continues its group or steps.
					if (cyc_done) begin
						if (kind == K_DATA) begin
							left <= left - 1'b1;
							state <= S_DATA;
						end else if ((kind == K_ADR5A || kind == K_ADR3A)
							&& sub != last_sub) begin
							sub <= sub + 3'd1;
							cyc_byte <= addr_byte(kind, sub + 3'd1, col, row_a);
							cyc_go <= 1'b1;
						end else if ((kind == K_ADR5B || kind == K_ADR3B)
							&& sub != last_sub) begin
							sub <= sub + 3'd1;
							cyc_byte <= addr_byte(kind, sub + 3'd1, col, row_b);
							cyc_go <= 1'b1;
						end else if (kind == K_COL2 && sub != last_sub) begin
							sub <= sub + 3'd1;
							cyc_byte <= rcol[15:8];
							cyc_go <= 1'b1;
						end else if (kind == K_STAT && sub == 3'd0) begin
							sub <= 3'd1;
							cyc_kind <= CYC_READ;
							cyc_go <= 1'b1;
						end else begin
							if (kind == K_STAT) begin
								// Keep only defined bits. [RULE_22]
								o_status <= cyc_rbyte & ((cyc_byte
									== CMD_PLANE_STATUS)
									? STAT_MASK_PLANE : STAT_MASK_BASIC); // [RULE_21]
								o_fail <= cyc_rbyte[STAT_FAIL_BIT]; // [RULE_18]
							end
							idx <= idx + 4'h1;
							state <= S_FETCH;
						end
					end
				end
				S_DATA: begin
					// Stream bytes in; the source is stalled by o_wready.
					if (left == '0) begin
						o_wready <= 1'b0;
						idx <= idx + 4'h1;
						state <= S_FETCH;
					end else if (o_wready && i_wvalid) begin
						o_wready <= 1'b0;
						kind <= K_DATA;
						cyc_kind <= CYC_WRITE;
						cyc_byte <= i_wdata;
						cyc_go <= 1'b1;
						state <= S_ISSUE;
					end else begin
						o_wready <= 1'b1;
					end
				end
				S_WAIT: begin
					// Give the device time to go busy, then await ready.
					if (wcnt != '0) begin
						wcnt <= wcnt - 1'b1;
					end else if (rb_s2) begin // [RULE_09]
						idx <= idx + 4'h1;
						state <= S_FETCH;
					end
				end
				S_FINISH: begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
					o_ce_n <= 1'b1;
					state <= S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Pin engine for single bus cycles.
	nand_bus_cycle u_cycle (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_go(cyc_go),
		.i_kind(cyc_kind),
		.i_byte(cyc_byte),
		.o_done(cyc_done),
		.o_rbyte(cyc_rbyte),
		.o_cle(o_cle),
		.o_ale(o_ale),
		.o_we_n(o_we_n),
		.o_read_strobe_n(o_read_strobe_n),
		.o_dq(o_dq),
		.o_dq_oe(o_dq_oe),
		.i_dq(i_dq)
	);

endmodule
`default_nettype wire

/* File: nand_dev_model.sv */
// Behavioural NAND device facing the sequencer's pins.
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
	parameter int BUSY_CYC = 10 // Busy time after a 10h, 11h, D0h, 35h or FFh command.
) (
	input wire logic i_clk_sys, // Clock.
	input wire logic i_cle, // Command latch enable.
	input wire logic i_we_n, // Write strobe, active low.
	input wire logic i_read_strobe_n, // Read strobe, active low.
	input wire logic i_wp_n, // Write protect, active low.
	input wire logic [7:0] i_dq, // Bus level.
	input wire logic i_fail, // Operations report failure.
	output logic [7:0] o_dq, // Drive value.
	output logic o_rb, // Ready/busy, low while busy.
	output logic [31:0] o_cmds // Last four commands.
);
	logic we_q = 1'b1; // Strobe one cycle ago.
	logic [7:0] last = 8'h00; // Last bus value.
	int cnt = 0; // Busy cycles left.
	initial o_cmds = 32'h0;
	// =========================
	// Commands latch on the rising write strobe.
	always @(posedge i_clk_sys) begin
		we_q <= i_we_n;
		last <= i_dq;
		if (cnt > 0)
			cnt <= cnt - 1;
		if (i_cle && i_we_n && !we_q) begin
			o_cmds <= {o_cmds[23:0], i_dq};
			if (i_dq inside {8'h10, 8'h11, 8'hd0, 8'h35, 8'hff})
				cnt <= BUSY_CYC;
		end
	end
	assign o_rb = (cnt == 0);
	// Status follows busy live; unused bits set so masking shows.
	wire logic [7:0] stat; // Status byte shown on every read.
	assign stat[7] = i_wp_n;
	assign stat[6] = o_rb;
	assign stat[5:3] = 3'b111;
	assign stat[2:0] = {3{i_fail}};
	// Reads answer status, as that mode stays until a new command.
	assign o_dq = i_read_strobe_n ? ~last : stat;
endmodule
`default_nettype wire

/* File: nand_seq_asserts.sv */
// Concurrent checks on the sequencer's ports.
`timescale 1ns/1ps
`default_nettype none
module nand_seq_asserts (
	input wire logic i_clk_sys, // Clock.
	input wire logic i_rst, // Reset.
	input wire logic i_start, // Start.
	input wire logic o_busy, o_done, o_refused, o_fail, o_wready, // Flags.
	input wire logic [7:0] o_status, // Status.
	input wire logic o_ce_n, o_cle, o_we_n, o_read_strobe_n, // Pins.
	input wire logic o_wp_n, o_dq_oe, o_ale // Pins.
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	sequence s_cmd_latch;
		o_cle && !o_we_n ##1 o_we_n;
	endsequence
	// =========================
	// Each check states a rule that an output must keep.
	a_refuse_cause: assert property (
		o_refused |-> $past(i_start) && !$past(o_busy)) else $error("bad refusal");
	a_done_single: assert property (
		o_done |=> !o_done) else $error("long done");
	a_wp_released: assert property (o_wp_n) else $error("wp low");
	a_status_masked: assert property (
		(o_status & 8'h38) == 8'h00) else $error("unmasked status");
	a_fail_bit: assert property (
		o_status[0] == o_fail) else $error("fail");
	a_cmd_hold: assert property (
		s_cmd_latch |-> o_cle && o_dq_oe) else $error("cmd hold");
	a_read_released: assert property (
		!o_read_strobe_n |-> !o_dq_oe) else $error("bus clash");
	a_strobe_chip: assert property (
		(!o_we_n || !o_read_strobe_n) |-> !o_ce_n) else $error("no ce");
	a_wready_busy: assert property (
		o_wready |-> o_busy) else $error("wr");
	a_latch_apart: assert property (
		!(o_cle && o_ale)) else $error("cle with ale");
endmodule
bind nand_program_erase_status_sequencer nand_seq_asserts chk (.*);
`default_nettype wire

/* File: nand_program_erase_status_sequencer_bench.sv */
// Self-checking bench for the NAND sequencer.
`timescale 1ns/1ps
`default_nettype none
module nand_program_erase_status_sequencer_bench;
	import nand_seq_pkg::*;
	logic i_clk_sys = 1'b0, i_rst = 1'b1, i_start = 1'b0, rnd = 1'b0;
	logic fail_on = 1'b0, refd, busy, done, refused, fail, ce_n, cle, ale;
	logic we_n, read_strobe_n, wp_n, oe, rb, wready;
	op_t op = OP_STATUS;
	logic [23:0] ra = 24'h0, rb_row = 24'h0;
	logic [13:0] len = 14'h0;
	logic [7:0] wdata = 8'h00, status, hdq, ddq;
	logic [31:0] cmds;
	wire logic [7:0] dq = oe ? hdq : ddq; // Bus level.
	int n_fail = 0, comparisons = 0, cycles = 0;
	nand_program_erase_status_sequencer uut (.i_clk_sys(i_clk_sys),
		.i_rst(i_rst), .i_start(i_start), .i_op(op), .i_col(16'h0004),
		.i_row_a(ra), .i_row_b(rb_row), .i_rand_en(rnd),
		.i_rand_col(16'h0010), .i_len(len), .i_wdata(wdata),
		.i_wvalid(1'b1), .o_wready(wready), .o_busy(busy), .o_done(done),
		.o_refused(refused), .o_status(status), .o_fail(fail),
		.o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n),
		.o_read_strobe_n(read_strobe_n), .o_wp_n(wp_n), .o_dq(hdq),
		.o_dq_oe(oe),
		.i_dq(dq), .i_rb(rb));
	nand_dev_model dev (.i_clk_sys(i_clk_sys), .i_cle(cle), .i_we_n(we_n),
		.i_read_strobe_n(read_strobe_n), .i_wp_n(wp_n), .i_dq(dq),
		.i_fail(fail_on),
		.o_dq(ddq), .o_rb(rb), .o_cmds(cmds));
	initial forever #25 i_clk_sys = ~i_clk_sys;
	// Next data byte once one is taken; cycle ceiling.
	always @(posedge i_clk_sys) begin
		if (wready)
			wdata <= #5 wdata + 8'h01;
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic chk(input string name, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, e, g);
		end
	endtask
	// One operation: start it, then wait for done or refusal.
	task automatic run(input op_t o, input logic [23:0] a, b,
		input logic r, f, input logic [13:0] n);
		@(posedge i_clk_sys) #5;
		op = o;
		ra = a;
		rb_row = b;
		rnd = r;
		fail_on = f;
		len = n;
		i_start = 1'b1;
		for (int k = 0; k < 3000; k++) begin
			@(posedge i_clk_sys) #5;
			i_start = 1'b0;
			refd = refused;
			if (done || refused)
				break;
		end
		chk("ended", 32'h1, {31'h0, done || refused});
	endtask
	task automatic t_erase;
		run(OP_ERASE, 24'h000105, 24'h0, 1'b0, 1'b1, 14'h0);
		chk("cmds", 32'h0060d070, cmds);
		chk("status", 32'hc1, {24'h0, status});
		chk("fail", 32'h1, {31'h0, fail});
	endtask
	task automatic t_erase2;
		run(OP_ERASE_2PLANE, 24'h05, 24'h45, 1'b0, 1'b0, 14'h0);
		chk("cmds", 32'h6060d0f1, cmds);
		chk("status", 32'hc0, {24'h0, status});
	endtask
	task automatic t_prog2;
		run(OP_PROG_2PLANE, 24'h08, 24'h48, 1'b0, 1'b1, 14'h2);
		chk("cmds", 32'h118110f1, cmds);
		chk("status", 32'hc7, {24'h0, status});
	endtask
	task automatic t_copy;
		run(OP_COPYBACK, 24'h10, 24'h20, 1'b1, 1'b0, 14'h1);
		chk("cmds", 32'h85851070, cmds);
	endtask
	task automatic t_rdcb;
		run(OP_READ_COPYBACK, 24'h10, 24'h0, 1'b0, 1'b0, 14'h0);
		chk("cmds", 32'h10700035, cmds);
	endtask
	task automatic t_refuse;
		run(OP_COPYBACK, 24'h10, 24'h50, 1'b0, 1'b0, 14'h0);
		chk("refused", 32'h1, {31'h0, refd});
		chk("cmds", 32'h10700035, cmds);
	endtask
	// Reset, a plain status poll, and a two-plane order that is refused.
	task automatic t_misc;
		run(OP_RESET, 24'h0, 24'h0, 1'b0, 1'b0, 14'h0);
		run(OP_STATUS, 24'h0, 24'h0, 1'b0, 1'b0, 14'h0);
		chk("cmds", 32'h0035ff70, cmds);
		chk("status", 32'hc0, {24'h0, status});
		run(OP_ERASE_2PLANE, 24'h45, 24'h05, 1'b0, 1'b0, 14'h0);
		chk("refused", 32'h1, {31'h0, refd});
	endtask
	task automatic end_of_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_clk_sys);
		#5 i_rst = 1'b0;
		t_erase();
		t_erase2();
		t_prog2();
		t_copy();
		t_rdcb();
		t_refuse();
		t_misc();
		end_of_test();
	end
endmodule
`default_nettype wire
